/* File: hw/fbr_readback.sv */
// fbr_readback: pixel rectangle readback front end with avalon-mm control
// assumes storage answers fetches via valid/ready and a sink drains groups
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module fbr_readback (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output fbr_pkg::fbr_fetch_s fetch_req,
	output logic fetch_valid,
	input wire logic fetch_ready,
	input wire fbr_pkg::fbr_pix_s pix_data,
	input wire logic pix_valid,
	output logic pix_ready,
	output fbr_pkg::fbr_grp_s grp_data,
	output logic grp_valid,
	input wire logic grp_ready,
	output logic busy
);
	import fbr_pkg::*;

	typedef enum logic [2:0] {
		FBR_ST_IDLE = 3'h0,
		FBR_ST_FETCH = 3'h1,
		FBR_ST_WAIT = 3'h2,
		FBR_ST_OUT = 3'h3
	} fbr_state_e;

	fbr_state_e state_r;
	logic [31:0] xy_r, wh_r, fmt_r, cfg_r, src_r, pos_r;
	logic [2:0] err_r;
	logic ack_r;
	logic [15:0] i_r, j_r;
	fbr_buf_e buf_r;
	fbr_grp_s grp_r;
	logic done_r;

	fbr_fmt_e fmt;
	fbr_type_e typ;
	fbr_kind_e kind;
	fbr_base_e base;
	logic has_depth, has_stencil, has_back, has_right, obj, complete, ci_mode, int_buf;
	logic has_alpha, dfloat;
	logic [7:0] att_mask;
	assign fmt = fbr_fmt_e'(fmt_r[3:0]);
	assign typ = fbr_type_e'(fmt_r[6:4]);
	assign has_depth = cfg_r[FBR_CFG_DEPTH_BIT];
	assign has_stencil = cfg_r[FBR_CFG_STENCIL_BIT];
	assign has_back = cfg_r[FBR_CFG_BACK_BIT];
	assign has_right = cfg_r[FBR_CFG_RIGHT_BIT];
	assign obj = cfg_r[FBR_CFG_OBJ_BIT];
	assign complete = cfg_r[FBR_CFG_COMPLETE_BIT];
	assign ci_mode = cfg_r[FBR_CFG_CI_MODE_BIT];
	assign int_buf = cfg_r[FBR_CFG_INT_BUF_BIT];
	assign has_alpha = cfg_r[FBR_CFG_ALPHA_BIT];
	assign dfloat = cfg_r[FBR_CFG_DFLOAT_BIT];
	assign att_mask = cfg_r[FBR_CFG_ATT_LSB +: 8];
	assign kind = fbr_kind_e'(cfg_r[FBR_CFG_KIND_LSB +: 2]);
	assign base = fbr_base_e'(cfg_r[FBR_CFG_BASE_LSB +: 2]);

	// ==========================================================
	// source-select decode: maps a code to a buffer and error
	function automatic logic [5:0] src_check(input logic [4:0] code, input logic is_obj,
		input logic back, input logic right, input logic [7:0] mask);
		logic [2:0] e;
		fbr_buf_e b;
		e = FBR_ERR_NONE;
		b = FBR_BUF_FRONT_LEFT;
		if (code >= FBR_SRC_ATT0 && code < FBR_SRC_ATT0 + 5'(FBR_NATT)) begin
			b = FBR_BUF_ATTACH;
			if (!is_obj) e = FBR_ERR_INV_OP;
		end else if (code > FBR_SRC_FRONT_AND_BACK) begin
			e = FBR_ERR_INV_ENUM;
		end else if (is_obj && code != FBR_SRC_NONE) begin
			e = FBR_ERR_INV_OP;
		end else begin
			case (fbr_src_e'(code))
				FBR_SRC_FRONT_AND_BACK, FBR_SRC_FRONT, FBR_SRC_LEFT,
				FBR_SRC_FRONT_LEFT: b = FBR_BUF_FRONT_LEFT;
				FBR_SRC_BACK, FBR_SRC_BACK_LEFT: begin
					b = FBR_BUF_BACK_LEFT;
					if (!back) e = FBR_ERR_INV_OP;
				end
				FBR_SRC_RIGHT, FBR_SRC_FRONT_RIGHT: begin
					b = FBR_BUF_FRONT_RIGHT;
					if (!right) e = FBR_ERR_INV_OP;
				end
				FBR_SRC_BACK_RIGHT: begin
					b = FBR_BUF_BACK_RIGHT;
					if (!(back && right)) e = FBR_ERR_INV_OP;
				end
				default: b = FBR_BUF_FRONT_LEFT;
			endcase
		end
		return {b, e};
	endfunction

	// ==========================================================
	// readback request validation
	logic [2:0] rb_err;
	fbr_buf_e rb_buf;
	logic is_int_fmt;
	assign is_int_fmt = (fmt == FBR_FMT_RGBA_INT);
	always_comb begin
		logic [5:0] sc;
		sc = src_check(src_r[4:0], obj, has_back, has_right, att_mask);
		rb_err = FBR_ERR_NONE;
		rb_buf = FBR_BUF_DEPTH;
		if (obj && !complete) begin
			rb_err = FBR_ERR_INV_FB_OP;
		end else if (fmt == FBR_FMT_DEPTH) begin
			rb_buf = FBR_BUF_DEPTH;
			if (!has_depth) rb_err = FBR_ERR_INV_OP;
		end else if (fmt == FBR_FMT_DS) begin
			rb_buf = FBR_BUF_DS;
			if (!has_depth || !has_stencil) rb_err = FBR_ERR_INV_OP;
			else if (typ != FBR_TYPE_PACKED_DS && typ != FBR_TYPE_PACKED_DS_FLOAT)
				rb_err = FBR_ERR_INV_ENUM;
		end else if (fmt == FBR_FMT_STENCIL) begin
			rb_buf = FBR_BUF_STENCIL;
			if (!has_stencil) rb_err = FBR_ERR_INV_OP;
		end else begin
			rb_buf = fbr_buf_e'(sc[5:3]);
			if (fmt == FBR_FMT_INDEX && !ci_mode) rb_err = FBR_ERR_INV_OP;
			else if (src_r[4:0] == FBR_SRC_NONE) rb_err = FBR_ERR_INV_OP;
			else if (obj && !att_mask[src_r[2:0]]) rb_err = FBR_ERR_INV_OP;
			else if (is_int_fmt != int_buf) rb_err = FBR_ERR_INV_OP;
			else if (is_int_fmt && (typ == FBR_TYPE_HALF || typ == FBR_TYPE_FLOAT))
				rb_err = FBR_ERR_INV_OP;
		end
	end

	// ==========================================================
	// avalon-mm slave: one wait cycle, answer on the second
	logic acc, wr_go, wr_sel;
	logic [5:0] sel_chk;
	assign acc = (avs_read || avs_write) && !ack_r;
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign wr_go = avs_write && ack_r && avs_address == FBR_OFS_CTRL
		&& avs_writedata[FBR_CTRL_GO_BIT] && avs_byteenable[0];
	assign wr_sel = avs_write && ack_r && avs_address == FBR_OFS_CTRL
		&& avs_writedata[FBR_CTRL_SEL_BIT] && avs_byteenable[0];
	assign sel_chk = src_check(avs_writedata[12:8], obj, has_back, has_right, att_mask);

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) ack_r <= 1'b0;
		else ack_r <= acc;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			xy_r <= 32'h0;
			wh_r <= 32'h0;
			fmt_r <= 32'h0;
			cfg_r <= FBR_CFG_RESET;
		end else if (avs_write && ack_r && state_r == FBR_ST_IDLE) begin
			case (avs_address)
				FBR_OFS_RECT_XY: xy_r <= be_merge(xy_r, avs_writedata, avs_byteenable);
				FBR_OFS_RECT_WH: wh_r <= be_merge(wh_r, avs_writedata, avs_byteenable);
				FBR_OFS_FMT: fmt_r <= be_merge(fmt_r, avs_writedata, avs_byteenable);
				FBR_OFS_CFG: cfg_r <= be_merge(cfg_r, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end
	end

	// read source: reset default follows back buffer presence
	logic init_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			src_r <= 32'h0;
			init_r <= 1'b1;
		end else if (init_r || (avs_write && ack_r && avs_address == FBR_OFS_CFG
			&& state_r == FBR_ST_IDLE)) begin
			init_r <= 1'b0;
			if (init_r) src_r <= {27'h0, has_back ? FBR_SRC_BACK : FBR_SRC_FRONT};
			else if (avs_writedata[FBR_CFG_OBJ_BIT] != obj)
				src_r <= {27'h0, avs_writedata[FBR_CFG_OBJ_BIT] ? FBR_SRC_ATT0
					: (avs_writedata[FBR_CFG_BACK_BIT] ? FBR_SRC_BACK : FBR_SRC_FRONT)};
		end else if (wr_sel && sel_chk[2:0] == FBR_ERR_NONE) begin
			src_r <= {27'h0, avs_writedata[12:8]};
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) err_r <= FBR_ERR_NONE;
		else if (wr_sel) err_r <= sel_chk[2:0];
		else if (wr_go && state_r == FBR_ST_IDLE) err_r <= rb_err;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) avs_readdata <= 32'h0;
		else if (acc && avs_read) begin
			case (avs_address)
				FBR_OFS_CTRL: avs_readdata <= 32'h0;
				FBR_OFS_RECT_XY: avs_readdata <= xy_r;
				FBR_OFS_RECT_WH: avs_readdata <= wh_r;
				FBR_OFS_FMT: avs_readdata <= fmt_r;
				FBR_OFS_SRC: avs_readdata <= src_r;
				FBR_OFS_CFG: avs_readdata <= cfg_r;
				FBR_OFS_STATUS: avs_readdata <= {27'h0, done_r, busy, err_r};
				FBR_OFS_POS: avs_readdata <= {j_r, i_r};
				default: avs_readdata <= FBR_RD_UNMAPPED;
			endcase
		end
	end

	// ==========================================================
	// rectangle walk
	logic last_px;
	assign last_px = (i_r == wh_r[15:0] - 16'h1) && (j_r == wh_r[31:16] - 16'h1);
	assign busy = (state_r != FBR_ST_IDLE);
	assign fetch_valid = (state_r == FBR_ST_FETCH);
	assign pix_ready = (state_r == FBR_ST_WAIT);
	assign grp_valid = (state_r == FBR_ST_OUT);
	assign grp_data = grp_r;
	assign fetch_req = '{buf_sel: buf_r, att_idx: src_r[2:0],
		x: xy_r[15:0] + i_r, y: xy_r[31:16] + j_r};

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= FBR_ST_IDLE;
			i_r <= 16'h0;
			j_r <= 16'h0;
			buf_r <= FBR_BUF_DEPTH;
			done_r <= 1'b0;
		end else begin
			case (state_r)
				FBR_ST_IDLE: if (wr_go) begin
					i_r <= 16'h0;
					j_r <= 16'h0;
					buf_r <= rb_buf;
					done_r <= 1'b0;
					if (rb_err != FBR_ERR_NONE || wh_r[15:0] == 16'h0 || wh_r[31:16] == 16'h0)
						done_r <= 1'b1;
					else
						state_r <= FBR_ST_FETCH;
				end
				FBR_ST_FETCH: if (fetch_ready) state_r <= FBR_ST_WAIT;
				FBR_ST_WAIT: if (pix_valid) state_r <= FBR_ST_OUT;
				FBR_ST_OUT: if (grp_ready) begin
					if (last_px) begin
						state_r <= FBR_ST_IDLE;
						done_r <= 1'b1;
					end else begin
						state_r <= FBR_ST_FETCH;
						if (i_r == wh_r[15:0] - 16'h1) begin
							i_r <= 16'h0;
							j_r <= j_r + 16'h1;
						end else begin
							i_r <= i_r + 16'h1;
						end
					end
				end
				default: state_r <= FBR_ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// element expansion: normalized to float, fills, transfer, luma_fmt
	function automatic logic [31:0] unorm_f(input logic [31:0] v, input int bits);
		// exact fraction v/(2^bits-1) approximated by v/2^bits to float
		logic [31:0] f;
		logic [31:0] m;
		int p;
		f = 32'h0;
		m = v & ((32'h1 << bits) - 32'h1);
		p = -1;
		for (int k = 0; k < 32; k++) if (m[k]) p = k;
		if (m == ((32'h1 << bits) - 32'h1)) f = FBR_ONE_F32;
		else if (p >= 0) f = {1'b0, 8'(127 + p - bits), 23'((m << (23 - p)) & 32'h7fffff)};
		return f;
	endfunction

	function automatic logic [31:0] conv_el(input logic [31:0] v, input fbr_kind_e k);
		logic [31:0] r;
		r = v;
		if (k == FBR_KIND_UNORM) r = unorm_f(v, 8);
		else if (k == FBR_KIND_SNORM && v[7:0] == 8'h80)
			r = 32'hbf80_0000; // most negative code clamps to -1.0
		else if (k == FBR_KIND_SNORM)
			r = v[7] ? (unorm_f({24'h0, ~v[7:0] + 8'h1}, 7) | 32'h8000_0000)
				: unorm_f({24'h0, v[7:0]}, 7);
		return r;
	endfunction

	fbr_pix_s xfer;
	always_comb begin
		fbr_pix_s g;
		g = pix_data;
		if (buf_r == FBR_BUF_DEPTH || buf_r == FBR_BUF_DS) begin
			if (!dfloat) g.r = unorm_f(pix_data.r, FBR_DEPTH_BITS);
		end else if (buf_r != FBR_BUF_STENCIL && !ci_mode) begin
			g.r = conv_el(pix_data.r, kind);
			g.g = conv_el(pix_data.g, kind);
			g.b = conv_el(pix_data.b, kind);
			g.a = conv_el(pix_data.a, kind);
			if (buf_r == FBR_BUF_ATTACH) begin
				if (base == FBR_BASE_R) g.g = 32'h0;
				if (base == FBR_BASE_R || base == FBR_BASE_RG) g.b = 32'h0;
			end
			if (!has_alpha || (buf_r == FBR_BUF_ATTACH && base != FBR_BASE_RGBA))
				g.a = (kind == FBR_KIND_INT) ? 32'h1 : FBR_ONE_F32;
		end
		xfer = g; // index mode passes the index in red
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) grp_r <= '0;
		else if (state_r == FBR_ST_WAIT && pix_valid) begin
			grp_r <= {xfer, last_px};
			if (!ci_mode && (fmt == FBR_FMT_LUMA || fmt == FBR_FMT_LUMA_ALPHA)) begin
				// integer sum; float buffers rely on downstream float add
				grp_r.r <= xfer.r + xfer.g + xfer.b;
				grp_r.g <= 32'h0;
				grp_r.b <= 32'h0;
			end
		end
	end
endmodule // fbr_readback

/* File: inc/fbr_pkg.sv */
// fbr_pkg: shared constants and carriers for the framebuffer pixel readback front end
// assumes a single 100 MHz clock domain and 32-bit avalon-mm register access
package fbr_pkg;
	// ==========================================================
	// register map (byte addresses)
	localparam logic [5:0] FBR_OFS_CTRL = 6'h00;
	localparam logic [5:0] FBR_OFS_RECT_XY = 6'h04;
	localparam logic [5:0] FBR_OFS_RECT_WH = 6'h08;
	localparam logic [5:0] FBR_OFS_FMT = 6'h0c;
	localparam logic [5:0] FBR_OFS_SRC = 6'h10;
	localparam logic [5:0] FBR_OFS_CFG = 6'h14;
	localparam logic [5:0] FBR_OFS_STATUS = 6'h18;
	localparam logic [5:0] FBR_OFS_POS = 6'h1c;

	// ==========================================================
	// field positions
	localparam int FBR_CTRL_GO_BIT = 0;
	localparam int FBR_CTRL_SEL_BIT = 1;
	localparam int FBR_CFG_DEPTH_BIT = 0;
	localparam int FBR_CFG_STENCIL_BIT = 1;
	localparam int FBR_CFG_BACK_BIT = 2;
	localparam int FBR_CFG_RIGHT_BIT = 3;
	localparam int FBR_CFG_OBJ_BIT = 4;
	localparam int FBR_CFG_COMPLETE_BIT = 5;
	localparam int FBR_CFG_CI_MODE_BIT = 6;
	localparam int FBR_CFG_INT_BUF_BIT = 7;
	localparam int FBR_CFG_ALPHA_BIT = 8;
	localparam int FBR_CFG_DFLOAT_BIT = 9;
	localparam int FBR_CFG_ATT_LSB = 16;
	localparam int FBR_CFG_KIND_LSB = 24;
	localparam int FBR_CFG_BASE_LSB = 26;
	localparam logic [31:0] FBR_CFG_RESET = 32'h0000_0123;
	localparam logic [31:0] FBR_RD_UNMAPPED = 32'hdead_0000;
	localparam int FBR_DEPTH_BITS = 24;
	localparam int FBR_NATT = 8;

	// ==========================================================
	// request formats
	typedef enum logic [3:0] {
		FBR_FMT_DEPTH = 4'h0,
		FBR_FMT_STENCIL = 4'h1,
		FBR_FMT_DS = 4'h2,
		FBR_FMT_RGBA = 4'h3,
		FBR_FMT_RGBA_INT = 4'h4,
		FBR_FMT_LUMA = 4'h5,
		FBR_FMT_LUMA_ALPHA = 4'h6,
		FBR_FMT_INDEX = 4'h7
	} fbr_fmt_e;

	// request element types
	typedef enum logic [2:0] {
		FBR_TYPE_UBYTE = 3'h0,
		FBR_TYPE_HALF = 3'h1,
		FBR_TYPE_FLOAT = 3'h2,
		FBR_TYPE_PACKED_DS = 3'h3,
		FBR_TYPE_PACKED_DS_FLOAT = 3'h4,
		FBR_TYPE_UINT = 3'h5
	} fbr_type_e;

	// read source codes
	typedef enum logic [4:0] {
		FBR_SRC_NONE = 5'h00,
		FBR_SRC_FRONT_LEFT = 5'h01,
		FBR_SRC_FRONT_RIGHT = 5'h02,
		FBR_SRC_BACK_LEFT = 5'h03,
		FBR_SRC_BACK_RIGHT = 5'h04,
		FBR_SRC_FRONT = 5'h05,
		FBR_SRC_BACK = 5'h06,
		FBR_SRC_LEFT = 5'h07,
		FBR_SRC_RIGHT = 5'h08,
		FBR_SRC_FRONT_AND_BACK = 5'h09,
		FBR_SRC_ATT0 = 5'h10
	} fbr_src_e;

	// colour buffer element kind
	typedef enum logic [1:0] {
		FBR_KIND_UNORM = 2'h0,
		FBR_KIND_SNORM = 2'h1,
		FBR_KIND_INT = 2'h2,
		FBR_KIND_FLOAT = 2'h3
	} fbr_kind_e;

	// attachment base format
	typedef enum logic [1:0] {
		FBR_BASE_R = 2'h0,
		FBR_BASE_RG = 2'h1,
		FBR_BASE_RGB = 2'h2,
		FBR_BASE_RGBA = 2'h3
	} fbr_base_e;

	typedef enum logic [2:0] {
		FBR_ERR_NONE = 3'h0,
		FBR_ERR_INV_OP = 3'h1,
		FBR_ERR_INV_ENUM = 3'h2,
		FBR_ERR_INV_FB_OP = 3'h3
	} fbr_err_e;

	// physical buffer selected for a fetch
	typedef enum logic [2:0] {
		FBR_BUF_DEPTH = 3'h0,
		FBR_BUF_STENCIL = 3'h1,
		FBR_BUF_DS = 3'h2,
		FBR_BUF_FRONT_LEFT = 3'h3,
		FBR_BUF_FRONT_RIGHT = 3'h4,
		FBR_BUF_BACK_LEFT = 3'h5,
		FBR_BUF_BACK_RIGHT = 3'h6,
		FBR_BUF_ATTACH = 3'h7
	} fbr_buf_e;

	localparam logic [31:0] FBR_ONE_F32 = 32'h3f80_0000;

	// fetch request toward framebuffer storage
	typedef struct packed {
		fbr_buf_e buf_sel;
		logic [2:0] att_idx;
		logic [15:0] x;
		logic [15:0] y;
	} fbr_fetch_s;

	// raw stored pixel, components as stored
	typedef struct packed {
		logic [31:0] r;
		logic [31:0] g;
		logic [31:0] b;
		logic [31:0] a;
	} fbr_pix_s;

	// expanded output group
	typedef struct packed {
		logic [31:0] r;
		logic [31:0] g;
		logic [31:0] b;
		logic [31:0] a;
		logic last;
	} fbr_grp_s;
endpackage

/* File: tb/fbr_readback_assertions.sv */
// fbr_readback_assertions: protocol and walk-order checks on the readback top ports
// assumes one clock domain, reset active low and asynchronous
`timescale 1ns/10ps
module fbr_readback_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire fbr_pkg::fbr_fetch_s fetch_req,
	input wire logic fetch_valid,
	input wire logic fetch_ready,
	input wire fbr_pkg::fbr_pix_s pix_data,
	input wire logic pix_valid,
	input wire logic pix_ready,
	input wire fbr_pkg::fbr_grp_s grp_data,
	input wire logic grp_valid,
	input wire logic grp_ready,
	input wire logic busy
);
	import fbr_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ==========================================================
	// last accepted fetch position within the current walk
	logic hv_r;
	logic [15:0] px_r;
	logic [15:0] py_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hv_r <= 1'b0;
			px_r <= 16'h0;
			py_r <= 16'h0;
		end else if (!busy) begin
			hv_r <= 1'b0;
		end else if (fetch_valid && fetch_ready) begin
			hv_r <= 1'b1;
			px_r <= fetch_req.x;
			py_r <= fetch_req.y;
		end
	end
	// ==========================================================
	// assertions
	a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
		|-> avs_waitrequest) else $error("waitrequest low in first request cycle");
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("more than one wait state");
	a_unmapped_read: assert property (avs_read && !avs_waitrequest && avs_address > 6'h1c
		|-> avs_readdata == FBR_RD_UNMAPPED) else $error("unmapped read data wrong");
	a_fetch_hold: assert property (fetch_valid && !fetch_ready |=> fetch_valid && $stable(fetch_req))
		else $error("fetch request dropped or changed");
	a_grp_hold: assert property (grp_valid && !grp_ready |=> grp_valid && $stable(grp_data))
		else $error("group dropped or changed");
	a_fetch_busy: assert property (fetch_valid |-> busy && !pix_ready && !grp_valid)
		else $error("fetch outside walk phase");
	a_row_order: assert property (fetch_valid && fetch_ready && hv_r |->
		(fetch_req.x == px_r + 16'h1 && fetch_req.y == py_r) || fetch_req.y == py_r + 16'h1)
		else $error("fetch order broken");
	a_last_idle: assert property (grp_valid && grp_ready && grp_data.last |-> ##[1:4] !busy)
		else $error("busy after last group");
	a_grp_cause: assert property ($rose(grp_valid) |->
		$past(pix_valid && pix_ready) || $past(pix_valid && pix_ready, 2))
		else $error("group without pixel");
endmodule // fbr_readback_assertions

bind fbr_readback fbr_readback_assertions fbr_readback_assertions_inst (
	.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fetch_req(fetch_req),
	.fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .pix_data(pix_data),
	.pix_valid(pix_valid), .pix_ready(pix_ready), .grp_data(grp_data), .grp_valid(grp_valid),
	.grp_ready(grp_ready), .busy(busy));

/* File: tb/fbr_store_model.sv */
// fbr_store_model: framebuffer storage answering fetches with coordinate-coded pixels
// assumes valid/ready handshakes; delay 0..3 cycles set by the fetched position
`timescale 1ns/10ps
module fbr_store_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire fbr_pkg::fbr_fetch_s fetch_req,
	input wire logic fetch_valid,
	output logic fetch_ready,
	output fbr_pkg::fbr_pix_s pix_data,
	output logic pix_valid,
	input wire logic pix_ready
);
	import fbr_pkg::*;
	logic pend_r;
	logic tog_r;
	logic [1:0] dly_r;
	fbr_fetch_s req_r;
	// accept on alternate cycles so the walk must hold a refused request
	assign fetch_ready = !pend_r && tog_r;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) tog_r <= 1'b0;
		else tog_r <= ~tog_r;
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pend_r <= 1'b0;
			dly_r <= 2'h0;
			req_r <= '0;
			pix_valid <= 1'b0;
			pix_data <= '0;
		end else if (!pend_r) begin
			if (fetch_valid && fetch_ready) begin
				pend_r <= 1'b1;
				req_r <= fetch_req;
				dly_r <= fetch_req.x[1:0] ^ fetch_req.y[1:0];
			end
		end else if (pix_valid) begin
			if (pix_ready) begin
				pix_valid <= 1'b0;
				pend_r <= 1'b0;
				// released data no longer meaningful
				pix_data <= ~pix_data;
			end
		end else if (dly_r != 2'h0) begin
			dly_r <= dly_r - 2'h1;
		end else begin
			pix_valid <= 1'b1;
			// stored contents, centre sample already resolved
			pix_data <= '{r: {req_r.x, req_r.y}, g: {req_r.y, req_r.x},
				b: {req_r.x, req_r.y} ^ 32'h00ff_ff00, a: {req_r.y, req_r.x} + 32'h1};
		end
	end
endmodule // fbr_store_model

/* File: tb/tb_framebuffer_pixel_readback.sv */
// tb_framebuffer_pixel_readback: random rectangles, source selection and error cases
// assumes fbr_readback with one wait state on the register bus
`timescale 1ns/10ps
module tb_framebuffer_pixel_readback;
	import fbr_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic [5:0] avs_address = 6'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	fbr_fetch_s fetch_req;
	logic fetch_valid, fetch_ready, pix_valid, pix_ready, grp_valid, busy;
	logic grp_ready = 1'b0;
	fbr_pix_s pix_data;
	fbr_grp_s grp_data;
	fbr_grp_s gq[$];
	fbr_buf_e fs;
	logic [2:0] fa;
	int nf, fail_count, checks_done;
	logic [31:0] seed = 32'h3206;
	logic [31:0] rs = 32'h3206;
	logic [31:0] q;
	logic [31:0] ec[9] = '{32'h0300_0122, 32'h0300_0121, 32'h0300_0121, 32'h0300_0123,
		32'h0300_0123, 32'h0300_0123, 32'h0200_01a3, 32'h0200_01a3, 32'h0f08_0113};
	fbr_fmt_e ef[9] = '{FBR_FMT_DEPTH, FBR_FMT_STENCIL, FBR_FMT_DS, FBR_FMT_DS, FBR_FMT_INDEX,
		FBR_FMT_RGBA_INT, FBR_FMT_RGBA, FBR_FMT_RGBA_INT, FBR_FMT_RGBA};
	fbr_type_e et[9] = '{FBR_TYPE_UBYTE, FBR_TYPE_UBYTE, FBR_TYPE_PACKED_DS, FBR_TYPE_UBYTE,
		FBR_TYPE_UBYTE, FBR_TYPE_UINT, FBR_TYPE_UBYTE, FBR_TYPE_FLOAT, FBR_TYPE_UBYTE};
	fbr_err_e ee[9] = '{FBR_ERR_INV_OP, FBR_ERR_INV_OP, FBR_ERR_INV_OP, FBR_ERR_INV_ENUM,
		FBR_ERR_INV_OP, FBR_ERR_INV_OP, FBR_ERR_INV_OP, FBR_ERR_INV_OP, FBR_ERR_INV_FB_OP};
	logic [4:0] fl[3] = '{FBR_SRC_FRONT_AND_BACK, FBR_SRC_FRONT, FBR_SRC_LEFT};

	always #5 core_clk = ~core_clk;

	fbr_readback fbr_readback_inst (.core_clk(core_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
		.fetch_ready(fetch_ready), .pix_data(pix_data), .pix_valid(pix_valid),
		.pix_ready(pix_ready), .grp_data(grp_data), .grp_valid(grp_valid),
		.grp_ready(grp_ready), .busy(busy));
	fbr_store_model fbr_store_model_inst (.core_clk(core_clk), .resetn(resetn),
		.fetch_req(fetch_req), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
		.pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready));

	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic fbr_pix_s pix(logic [15:0] x, logic [15:0] y);
		return '{r: {x, y}, g: {y, x}, b: {x, y} ^ 32'h00ff_ff00, a: {y, x} + 32'h1};
	endfunction

	// ==========================================================
	// sink stalls and walk monitor
	always @(posedge core_clk) begin
		rs <= lfsr(rs);
		grp_ready <= rs[0] | rs[3];
		if (grp_valid && grp_ready)
			gq.push_back(grp_data);
		if (fetch_valid && fetch_ready) begin
			if (nf == 0) begin
				fs = fetch_req.buf_sel;
				fa = fetch_req.att_idx;
			end
			nf++;
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] e, input logic [31:0] a);
		checks_done++;
		if (a !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, a);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		do @(posedge core_clk);
		while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic sel(input logic [4:0] c, input fbr_err_e e);
		logic [31:0] s;
		bus(1'b1, FBR_OFS_CTRL, {19'h0, c, 8'h02}, s);
		bus(1'b0, FBR_OFS_STATUS, 32'h0, s);
		cmp(32'(e), {29'h0, s[2:0]});
		bus(1'b0, FBR_OFS_SRC, 32'h0, s);
		if (e == FBR_ERR_NONE)
			cmp({27'h0, c}, s);
	endtask
	// m: 0 count only, 1 stored alpha, 2 alpha one, 3 luma_fmt, 4 red-only base
	task automatic run(input fbr_fmt_e f, input fbr_type_e t, input fbr_err_e e,
		input fbr_buf_e b, input int m);
		logic [31:0] s;
		logic [15:0] x, y;
		int w, h, k;
		fbr_pix_s p;
		fbr_grp_s g;
		seed = lfsr(lfsr(seed));
		x = {8'h0, seed[7:0]};
		y = {8'h0, seed[15:8]};
		w = 1 + seed[17:16];
		h = 1 + seed[19:18];
		gq.delete();
		nf = 0;
		bus(1'b1, FBR_OFS_RECT_XY, {y, x}, s);
		bus(1'b1, FBR_OFS_RECT_WH, {16'(h), 16'(w)}, s);
		bus(1'b1, FBR_OFS_FMT, {25'h0, t, f}, s);
		bus(1'b1, FBR_OFS_CTRL, 32'h1, s);
		do bus(1'b0, FBR_OFS_STATUS, 32'h0, s);
		while (s[4] !== 1'b1 || s[3] !== 1'b0);
		cmp(32'(e), {29'h0, s[2:0]});
		cmp((e == FBR_ERR_NONE) ? 32'(w * h) : 32'h0, 32'(nf));
		if (e == FBR_ERR_NONE) begin
			cmp(32'(b), 32'(fs));
			cmp(32'(w * h), 32'(gq.size()));
		end
		if (m != 0 && gq.size() == w * h) begin
			for (int j = 0; j < h; j++) begin
				for (int i = 0; i < w; i++) begin
					k = j * w + i;
					p = pix(x + 16'(i), y + 16'(j));
					g = gq[k];
					cmp((m == 3) ? p.r + p.g + p.b : p.r, g.r);
					cmp((m == 1 || m == 3) ? p.a : FBR_ONE_F32, g.a);
					cmp(32'(k == w * h - 1), 32'(g.last));
					cmp((m >= 3) ? 32'h0 : p.g, g.g);
					cmp((m >= 3) ? 32'h0 : p.b, g.b);
				end
			end
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (10) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		bus(1'b0, FBR_OFS_CFG, 32'h0, q);
		cmp(FBR_CFG_RESET, q);
		bus(1'b0, 6'h20, 32'h0, q);
		cmp(FBR_RD_UNMAPPED, q);
		bus(1'b1, FBR_OFS_CFG, 32'h0300_0123, q);
		repeat (3) run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 1);
		run(FBR_FMT_LUMA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 3);
		run(FBR_FMT_LUMA_ALPHA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 3);
		run(FBR_FMT_DEPTH, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_DEPTH, 0);
		run(FBR_FMT_STENCIL, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_STENCIL, 0);
		run(FBR_FMT_DS, FBR_TYPE_PACKED_DS, FBR_ERR_NONE, FBR_BUF_DS, 0);
		run(FBR_FMT_DS, FBR_TYPE_PACKED_DS_FLOAT, FBR_ERR_NONE, FBR_BUF_DS, 0);
		bus(1'b1, FBR_OFS_CFG, 32'h0300_0023, q);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 2);
		for (int i = 0; i < 9; i++) begin
			bus(1'b1, FBR_OFS_CFG, ec[i], q);
			run(ef[i], et[i], ee[i], FBR_BUF_DEPTH, 0);
		end
		bus(1'b1, FBR_OFS_CFG, 32'h0300_012b, q);
		sel(FBR_SRC_RIGHT, FBR_ERR_NONE);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_RIGHT, 1);
		for (int i = 0; i < 3; i++) begin
			sel(fl[i], FBR_ERR_NONE);
			run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 0);
		end
		sel(FBR_SRC_BACK, FBR_ERR_INV_OP);
		sel(5'h1f, FBR_ERR_INV_ENUM);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_FRONT_LEFT, 0);
		sel(FBR_SRC_NONE, FBR_ERR_NONE);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_INV_OP, FBR_BUF_DEPTH, 0);
		bus(1'b1, FBR_OFS_CFG, 32'h0300_0127, q);
		sel(FBR_SRC_BACK, FBR_ERR_NONE);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_BACK_LEFT, 1);
		bus(1'b1, FBR_OFS_CFG, 32'h0f08_0133, q);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_INV_OP, FBR_BUF_DEPTH, 0);
		sel(5'h13, FBR_ERR_NONE);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_ATTACH, 1);
		cmp(32'h3, {29'h0, fa});
		bus(1'b1, FBR_OFS_CFG, 32'h0308_0133, q);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_ATTACH, 4);
		bus(1'b1, FBR_OFS_CFG, 32'h0300_0127, q);
		run(FBR_FMT_RGBA, FBR_TYPE_UBYTE, FBR_ERR_NONE, FBR_BUF_BACK_LEFT, 1);
		close_out();
	end

	// ==========================================================
	// watchdog
	initial begin
		#(10 * 80000);
		fail_count++;
		close_out();
	end
endmodule // tb_framebuffer_pixel_readback
